// *** src/gwc_pkg.sv ***
// shared constants for the gateway clear and error control block
package gwc_pkg;
  // register byte addresses
  localparam logic [31:0] GWC_CLR_ADDR = 32'h04001E00; // clear control, write only
  localparam logic [31:0] GWC_CFG_ADDR = 32'h04000020; // high speed address config
  localparam logic [31:0] GWC_ERR_ADDR = 32'h04001E04; // error status, read only
  localparam logic [31:0] GWC_IFL_ADDR = 32'h04001E08; // interface flags, read only
  // clear control register layout
  localparam int GWC_CLR_W   = 11; // bits 0..10 carry an action
  localparam int CB_LS_IN    = 0;  // low speed input control
  localparam int CB_LS_OUT   = 1;  // low speed output control
  localparam int CB_HS_ADDR  = 2;  // high speed address control
  localparam int CB_HS_DATA  = 3;  // high speed data control
  localparam int CB_RD_PTR   = 4;  // buffer readout address
  localparam int CB_RWAIT    = 5;  // ready waiting flag
  localparam int CB_FLUSH    = 6;  // buffer and priority
  localparam int CB_LS_IERR  = 7;  // input error flags
  localparam int CB_LS_OERR  = 8;  // output error flags
  localparam int CB_LS_DISC  = 9;  // input disconnect
  localparam int CB_LS_DAV   = 10; // input data available
  // error status layout
  localparam int E_CLR_CH = 0;  // clear channel mirror, slave
  localparam int E_NO_SEC = 1;  // disable secded mirror, slave
  localparam int E_BLK    = 2;  // block (length) error
  localparam int E_LIP    = 3;  // low speed input parity
  localparam int E_LIS    = 4;  // low speed input sequence
  localparam int E_PC_LO  = 5;  // parcel count, 3 bits
  localparam int E_RDP    = 8;  // readout parity
  localparam int E_AP     = 9;  // address parity
  localparam int E_LOP    = 10; // low speed output parity
  localparam int E_LOS    = 11; // low speed output sequence
  localparam int E_ARE    = 12; // address ready error
  localparam int E_UNR    = 13; // unrecoverable line, slave
  // interface flag layout
  localparam int F_DAV   = 7;  // input data available
  localparam int F_DISC  = 8;  // input disconnect
  localparam int F_IERR  = 9;  // input error summary
  localparam int F_OFL   = 10; // output flag
  localparam int F_OERR  = 11; // output error summary
  localparam int F_RWAIT = 12; // ready waiting
  localparam int F_PRIO  = 13; // latched input priority
  localparam int F_HAE   = 14; // held address error, master
  localparam int F_HUE   = 15; // held unrecoverable, master
  localparam int GWC_FW  = 16; // width of status vectors
  // config bit that drives the unrecoverable line
  localparam int CFG_UNR_BIT = 8;
  // pin sync vector layout
  localparam int P_CC   = 0; // clear channel
  localparam int P_AE   = 1; // address error line
  localparam int P_UE   = 2; // unrecoverable line
  localparam int P_NS   = 3; // disable secded
  localparam int P_OUT  = 4; // output node strap
  localparam int P_SLV  = 5; // slave gateway strap
  localparam int P_W    = 6;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** src/gwc_sync.sv ***
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module gwc_sync
  import gwc_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // both stages in one state word
  typedef struct packed {
    logic [W-1:0] s1; // first stage, read only by s2
    logic [W-1:0] s2; // settled stage
  } gwc_sync_t;

  gwc_sync_t st_r;
  gwc_sync_t st_nxt;

  // shift pins through two stages
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // register the stages
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.s2;
endmodule

// *** src/gwc_flags.sv ***
// vector of sticky flags, set wins over clear
`timescale 1ns/1ps
module gwc_flags
  import gwc_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  // flag bits as the only state
  typedef struct packed {
    logic [W-1:0] f;
  } gwc_flags_t;

  gwc_flags_t st_r;
  gwc_flags_t st_nxt;

  // an event in the clear cycle survives
  always_comb
  begin
    st_nxt   = st_r;
    st_nxt.f = (st_r.f & ~clr) | set;
  end

  // register the flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.f;
endmodule

// *** src/gwc_ctrl.sv ***
// gateway error flags and clear control with axi4-lite registers
// How it works
// - address parity error sets status bit 9
// - only clear bit 2 clears bit 9
// - unexpected address ready sets bit 12
// - slave: clear channel holds unrecoverable line
// - clear register write-only, ones act, zeros ignored
// - input node bit 0: flags, errors, input machine
// - output node bit 0: flags, errors only
// - bit 1 clears output bits; output node machine
// - master bit 2 drops held channel errors
// - slave bit 2 clears 9, 12, addressing
// - bit 3 clears 2, 8, slave 0-1, data
// - master bit 3 also resets addressing
// - bit 4 zeroes node buffer pointer
// - ready without resume sets waiting; bit 5 clears
// - input node bit 6 flushes buffer, priority
// - output node bit 6 flushes output buffer
// - bit 7 clears input parity, sequence, summary
// - bit 8 clears output parity, sequence, summary
// - bit 9 clears input disconnect flag
// - bit 10 clears input data available
`timescale 1ns/1ps
module gwc_ctrl
  import gwc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // channel pins and straps, asynchronous
  input  wire logic        hs_clear_channel_pin,
  input  wire logic        hs_addr_error_pin,
  input  wire logic        hs_unrecov_pin,
  input  wire logic        hs_no_secded_pin,
  input  wire logic        node_output_pin,
  input  wire logic        gateway_slave_pin,
  // one-cycle events from channel logic
  input  wire logic        ev_addr_parity,
  input  wire logic        ev_addr_ready_unexp,
  input  wire logic        ev_block_err,
  input  wire logic        ev_readout_parity,
  input  wire logic        ev_ls_in_parity,
  input  wire logic        ev_ls_in_seq,
  input  wire logic        ev_ls_out_parity,
  input  wire logic        ev_ls_out_seq,
  input  wire logic        ev_ls_data_avail,
  input  wire logic        ev_ls_disconnect,
  input  wire logic        ev_ls_out_flag,
  input  wire logic        ev_ls_ready,
  input  wire logic        ev_ls_resume,
  input  wire logic        ev_first_parcel,
  input  wire logic        parcel_bit15,
  input  wire logic        parcel_count_we,
  input  wire logic [2:0]  parcel_count,
  // clear pulses and status
  output logic             hs_unrecov_drive,
  output logic             ls_in_sm_reset,
  output logic             ls_out_sm_reset,
  output logic             hs_addr_reset,
  output logic             hs_data_reset,
  output logic             hs_in_ptr_reset,
  output logic             hs_out_ptr_reset,
  output logic             ls_in_flush,
  output logic             ls_out_flush,
  output logic [15:0]      err_status,
  output logic [15:0]      iflags
);
  // registered pulse vector positions
  localparam int PU_LSI = 0; // input machine reset
  localparam int PU_LSO = 1; // output machine reset
  localparam int PU_HSA = 2; // addressing reset
  localparam int PU_HSD = 3; // data reset
  localparam int PU_IPT = 4; // input buffer pointer
  localparam int PU_OPT = 5; // output buffer pointer
  localparam int PU_IFL = 6; // input buffer flush
  localparam int PU_OFL = 7; // output buffer flush
  localparam int PU_W   = 8;

  // all block state
  typedef struct packed {
    logic              awready; // address slot free
    logic              wready;  // data slot free
    logic              aw_got;  // address held
    logic [31:0]       awaddr;  // held write address
    logic              w_got;   // data held
    logic [31:0]       wdata;   // held write data
    logic [3:0]        wstrb;   // held strobes
    logic              bvalid;  // write answer
    logic [1:0]        bresp;   // write answer code
    logic              arready; // read slot free
    logic              rvalid;  // read answer
    logic [31:0]       rdata;   // read data
    logic [1:0]        rresp;   // read answer code
    logic [PU_W-1:0]   pulse;   // clear pulses out
    logic [2:0]        pcount;  // valid parcel count
  } gwc_ctrl_t;

  gwc_ctrl_t st_r;
  gwc_ctrl_t st_nxt;

  logic [P_W-1:0]    pin_s;    // synchronised pins
  logic [GWC_FW-1:0] err_q;    // error flags
  logic [GWC_FW-1:0] ifl_q;    // interface flags
  logic [GWC_FW-1:0] err_set;  // error set terms
  logic [GWC_FW-1:0] err_clr;  // error clear terms
  logic [GWC_FW-1:0] ifl_set;  // flag set terms
  logic [GWC_FW-1:0] ifl_clr;  // flag clear terms
  logic [31:0]       bmask;    // strobe byte mask
  logic [31:0]       wmasked;  // data under strobes
  logic              wr_fire;  // write performed now
  logic              wr_clr;   // write hits clear reg
  logic              wr_cfg;   // write hits config reg
  logic [GWC_CLR_W-1:0] clr;   // clear actions this cycle
  logic              is_out;   // output node
  logic              is_slv;   // slave gateway
  logic              cfg_unr0; // config writes line low
  logic [31:0]       rd_val;   // read mux value
  logic [1:0]        rd_resp;  // read mux answer

  // pins pass two flops first
  gwc_sync #(
    .W (P_W)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({gateway_slave_pin, node_output_pin, hs_no_secded_pin,
                hs_unrecov_pin, hs_addr_error_pin, hs_clear_channel_pin}),
    .q       (pin_s)
  );

  assign is_out = pin_s[P_OUT];
  assign is_slv = pin_s[P_SLV];

  // strobe expansion and write decode
  always_comb
  begin
    bmask   = {{8{st_r.wstrb[3]}}, {8{st_r.wstrb[2]}},
               {8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};
    wmasked = st_r.wdata & bmask;
    wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
    wr_clr  = wr_fire & (st_r.awaddr == GWC_CLR_ADDR);
    wr_cfg  = wr_fire & (st_r.awaddr == GWC_CFG_ADDR);
    clr     = wr_clr ? wmasked[GWC_CLR_W-1:0] : '0;
    cfg_unr0 = wr_cfg & bmask[CFG_UNR_BIT] & ~st_r.wdata[CFG_UNR_BIT];
  end

  // error status set and clear terms
  always_comb
  begin
    err_set = '0;
    err_clr = '0;
    // slave mirrors of channel lines
    err_set[E_CLR_CH] = is_slv & pin_s[P_CC];
    err_set[E_NO_SEC] = is_slv & pin_s[P_NS];
    err_set[E_BLK]    = ev_block_err;
    err_set[E_LIP]    = ev_ls_in_parity;
    err_set[E_LIS]    = ev_ls_in_seq;
    err_set[E_RDP]    = ev_readout_parity;
    err_set[E_AP]     = ev_addr_parity;
    err_set[E_LOP]    = ev_ls_out_parity;
    err_set[E_LOS]    = ev_ls_out_seq;
    err_set[E_ARE]    = ev_addr_ready_unexp;
    err_set[E_UNR]    = is_slv & pin_s[P_CC];
    err_clr[E_CLR_CH] = clr[CB_HS_DATA] & is_slv;
    err_clr[E_NO_SEC] = clr[CB_HS_DATA] & is_slv;
    err_clr[E_BLK]    = clr[CB_HS_DATA];
    err_clr[E_RDP]    = clr[CB_HS_DATA];
    err_clr[E_LIP]    = clr[CB_LS_IN] | clr[CB_LS_IERR];
    err_clr[E_LIS]    = clr[CB_LS_IN] | clr[CB_LS_IERR];
    err_clr[E_AP]     = clr[CB_HS_ADDR];
    err_clr[E_ARE]    = clr[CB_HS_ADDR];
    err_clr[E_LOP]    = clr[CB_LS_OUT] | clr[CB_LS_OERR];
    err_clr[E_LOS]    = clr[CB_LS_OUT] | clr[CB_LS_OERR];
    err_clr[E_UNR]    = cfg_unr0;
  end

  // interface flag set and clear terms
  always_comb
  begin
    ifl_set = '0;
    ifl_clr = '0;
    ifl_set[F_DAV]   = ev_ls_data_avail;
    ifl_set[F_DISC]  = ev_ls_disconnect;
    ifl_set[F_IERR]  = ev_ls_in_parity | ev_ls_in_seq;
    ifl_set[F_OFL]   = ev_ls_out_flag;
    ifl_set[F_OERR]  = ev_ls_out_parity | ev_ls_out_seq;
    ifl_set[F_RWAIT] = ev_ls_ready & ~ev_ls_resume;
    ifl_set[F_PRIO]  = ev_first_parcel & parcel_bit15;
    ifl_set[F_HAE]   = ~is_slv & pin_s[P_AE];
    ifl_set[F_HUE]   = ~is_slv & pin_s[P_UE];
    ifl_clr[F_DAV]   = clr[CB_LS_IN] | clr[CB_LS_DAV];
    ifl_clr[F_DISC]  = clr[CB_LS_IN] | clr[CB_LS_DISC];
    ifl_clr[F_IERR]  = clr[CB_LS_IN] | clr[CB_LS_IERR];
    ifl_clr[F_OFL]   = clr[CB_LS_OUT];
    ifl_clr[F_OERR]  = clr[CB_LS_OUT] | clr[CB_LS_OERR];
    // waiting flag only by bit 5
    ifl_clr[F_RWAIT] = clr[CB_RWAIT];
    ifl_clr[F_PRIO]  = clr[CB_FLUSH] & ~is_out;
    ifl_clr[F_HAE]   = clr[CB_HS_ADDR] & ~is_slv;
    ifl_clr[F_HUE]   = clr[CB_HS_ADDR] & ~is_slv;
  end

  // sticky error status bits
  gwc_flags #(
    .W (GWC_FW)
  ) u_err (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (err_set),
    .clr     (err_clr),
    .q       (err_q)
  );

  // sticky interface flag bits
  gwc_flags #(
    .W (GWC_FW)
  ) u_ifl (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (ifl_set),
    .clr     (ifl_clr),
    .q       (ifl_q)
  );

  // read data selection
  always_comb
  begin
    rd_val  = '0;
    rd_resp = RESP_OKAY;
    case (s_axi_araddr)
      // write-only registers read zero
      GWC_CLR_ADDR: rd_val = '0;
      GWC_CFG_ADDR: rd_val = '0;
      GWC_ERR_ADDR: rd_val = {16'h0000, err_status};
      GWC_IFL_ADDR: rd_val = {16'h0000, ifl_q};
      // unmapped answers with error
      default:      rd_resp = RESP_SLVERR;
    endcase
  end

  // next state of bus and pulses
  always_comb
  begin
    st_nxt = st_r;
    // take write address
    if (s_axi_awvalid && st_r.awready)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    // take write data
    if (s_axi_wvalid && st_r.wready)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    // perform write, raise answer
    if (wr_fire)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = (wr_clr || wr_cfg ||
                       st_r.awaddr == GWC_ERR_ADDR ||
                       st_r.awaddr == GWC_IFL_ADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    // slots reopen after the answer
    st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
    st_nxt.wready  = ~st_nxt.w_got & ~st_nxt.bvalid;
    // read request and answer
    if (s_axi_arvalid && st_r.arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_val;
      st_nxt.rresp  = rd_resp;
    end
    else if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = ~st_nxt.rvalid;
    // one pulse per write of one
    st_nxt.pulse = '0;
    st_nxt.pulse[PU_LSI] = clr[CB_LS_IN] & ~is_out;
    st_nxt.pulse[PU_LSO] = clr[CB_LS_OUT] & is_out;
    st_nxt.pulse[PU_HSA] = (clr[CB_HS_ADDR] & is_slv) |
                           (clr[CB_HS_DATA] & ~is_slv);
    st_nxt.pulse[PU_HSD] = clr[CB_HS_DATA];
    st_nxt.pulse[PU_IPT] = clr[CB_RD_PTR] & ~is_out;
    st_nxt.pulse[PU_OPT] = clr[CB_RD_PTR] & is_out;
    st_nxt.pulse[PU_IFL] = clr[CB_FLUSH] & ~is_out;
    st_nxt.pulse[PU_OFL] = clr[CB_FLUSH] & is_out;
    // parcel count, load wins over clear
    if (parcel_count_we)
      st_nxt.pcount = parcel_count;
    else if (clr[CB_LS_IN])
      st_nxt.pcount = '0;
  end

  // register the state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // status vector with parcel count
  always_comb
  begin
    err_status = err_q;
    err_status[E_PC_LO +: 3] = st_r.pcount;
  end

  // outputs straight from flops
  assign s_axi_awready    = st_r.awready;
  assign s_axi_wready     = st_r.wready;
  assign s_axi_bvalid     = st_r.bvalid;
  assign s_axi_bresp      = st_r.bresp;
  assign s_axi_arready    = st_r.arready;
  assign s_axi_rvalid     = st_r.rvalid;
  assign s_axi_rdata      = st_r.rdata;
  assign s_axi_rresp      = st_r.rresp;
  assign hs_unrecov_drive = err_q[E_UNR];
  assign ls_in_sm_reset   = st_r.pulse[PU_LSI];
  assign ls_out_sm_reset  = st_r.pulse[PU_LSO];
  assign hs_addr_reset    = st_r.pulse[PU_HSA];
  assign hs_data_reset    = st_r.pulse[PU_HSD];
  assign hs_in_ptr_reset  = st_r.pulse[PU_IPT];
  assign hs_out_ptr_reset = st_r.pulse[PU_OPT];
  assign ls_in_flush      = st_r.pulse[PU_IFL];
  assign ls_out_flush     = st_r.pulse[PU_OFL];
  assign iflags           = ifl_q;
endmodule

// *** test/gwc_ctrl_assertions.sv ***
// port assertions for the gateway clear block
`timescale 1ns/1ps
module gwc_ctrl_assertions
  import gwc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        ev_addr_parity,
  input wire logic        ev_addr_ready_unexp,
  input wire logic        hs_unrecov_drive,
  input wire logic        hs_data_reset,
  input wire logic        ls_in_sm_reset,
  input wire logic [15:0] err_status
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_resp_lat:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write answer not two edges after request");
  a_write_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
  a_read_resp_lat:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
  a_read_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_ap_set:
    assert property (ev_addr_parity |=> err_status[E_AP]) else $error("parity flag not set");
  a_are_set:
    assert property (ev_addr_ready_unexp |=> err_status[E_ARE])
      else $error("address ready flag not set");
  a_ap_clear_time:
    assert property ($fell(err_status[E_AP]) |-> $rose(s_axi_bvalid))
      else $error("parity flag cleared without a write");
  a_unrecov_hold:
    assert property ($fell(hs_unrecov_drive) |-> $rose(s_axi_bvalid))
      else $error("unrecoverable line dropped without a write");
  a_data_rst_time:
    assert property (hs_data_reset |-> s_axi_bvalid && !$past(s_axi_bvalid))
      else $error("data reset pulse at wrong time");
  a_in_sm_pulse:
    assert property (ls_in_sm_reset |=> !ls_in_sm_reset) else $error("pulse too long");
  c_data_rst: cover property (hs_data_reset);
  c_in_sm_rst: cover property (ls_in_sm_reset);
  c_ap_clear: cover property ($fell(err_status[E_AP]));
endmodule

// *** test/gwc_host_model.sv ***
// host side model driving the high speed channel levels
`timescale 1ns/1ps
module gwc_host_model (
  input  wire logic       aclk,
  input  wire logic [3:0] want,
  output logic            clear_channel,
  output logic            addr_error,
  output logic            unrecov,
  output logic            no_secded
);
  // levels move only on a clock edge, as the host drivers do
  always_ff @(posedge aclk)
  begin
    {no_secded, unrecov, addr_error, clear_channel} <= want;
  end
endmodule

// *** test/tb_io_gateway_clear_error_ctrl.sv ***
// self-checking bench for the gateway clear block
`timescale 1ns/1ps
module tb_io_gateway_clear_error_ctrl
  import gwc_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, node_output_pin, gateway_slave_pin, hs_unrecov_drive;
  logic        hs_clear_channel_pin, hs_addr_error_pin, hs_unrecov_pin, hs_no_secded_pin;
  logic        ls_in_sm_reset, ls_out_sm_reset, hs_addr_reset, hs_data_reset;
  logic        hs_in_ptr_reset, hs_out_ptr_reset, ls_in_flush, ls_out_flush;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  s_axi_wstrb, want;
  logic [13:0] ev;
  logic [15:0] err_status, iflags;
  logic [7:0]  seen;
  logic [2:0]  pc;
  logic        pcwe;
  int          failures, checks_done;
  // event index, flag vector, flag bit, clear bit
  int          rows [14][4] = '{'{0,0,9,2}, '{1,0,12,2}, '{2,0,2,3}, '{3,0,8,3},
    '{4,0,3,7}, '{5,0,4,0}, '{6,0,10,8}, '{7,0,11,1}, '{8,1,7,10}, '{9,1,8,9},
    '{10,1,10,1}, '{11,1,12,5}, '{13,1,13,6}, '{4,1,9,7}};
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  gwc_host_model host_u (.aclk, .want, .clear_channel(hs_clear_channel_pin),
    .addr_error(hs_addr_error_pin), .unrecov(hs_unrecov_pin), .no_secded(hs_no_secded_pin));
  gwc_ctrl dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hs_clear_channel_pin,
    .hs_addr_error_pin, .hs_unrecov_pin, .hs_no_secded_pin, .node_output_pin,
    .gateway_slave_pin, .ev_addr_parity(ev[0]), .ev_addr_ready_unexp(ev[1]),
    .ev_block_err(ev[2]), .ev_readout_parity(ev[3]), .ev_ls_in_parity(ev[4]),
    .ev_ls_in_seq(ev[5]), .ev_ls_out_parity(ev[6]), .ev_ls_out_seq(ev[7]),
    .ev_ls_data_avail(ev[8]), .ev_ls_disconnect(ev[9]), .ev_ls_out_flag(ev[10]),
    .ev_ls_ready(ev[11]), .ev_ls_resume(ev[12]), .ev_first_parcel(ev[13]),
    .parcel_bit15(1'b1), .parcel_count_we(pcwe), .parcel_count(pc), .hs_unrecov_drive,
    .ls_in_sm_reset, .ls_out_sm_reset, .hs_addr_reset, .hs_data_reset, .hs_in_ptr_reset,
    .hs_out_ptr_reset, .ls_in_flush, .ls_out_flush, .err_status, .iflags);
  // gather clear pulses where they are settled
  always @(negedge aclk)
    seen = seen | {ls_out_flush, ls_in_flush, hs_out_ptr_reset, hs_in_ptr_reset,
                   hs_data_reset, hs_addr_reset, ls_out_sm_reset, ls_in_sm_reset};
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // one-cycle event pulses
  task automatic fire(input logic [13:0] m);
    ev <= m;
    @(posedge aclk);
    ev <= '0;
  endtask
  // write: hold each channel until taken, ready levels looked at mid-cycle
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    hb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb)
    begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a);
    logic h, hd;
    hd = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hd)
    begin
      @(negedge aclk);
      h = s_axi_arvalid && s_axi_arready;
      hd = s_axi_rvalid;
      rdq = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (h) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  // pulses expected per clear bit: output node, slave gateway
  function automatic logic [7:0] pexp(input int b, input bit o, input bit s);
    case (b)
      0: return o ? 8'h00 : 8'h01;
      1: return o ? 8'h02 : 8'h00;
      2: return s ? 8'h04 : 8'h00;
      3: return s ? 8'h08 : 8'h0C;
      4: return o ? 8'h20 : 8'h10;
      6: return o ? 8'h80 : 8'h40;
      default: return 8'h00;
    endcase
  endfunction
  initial
  begin
    wt(20000);
    failures++;
    complete_run();
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, want, ev, seen, pc, pcwe} = '0;
    {node_output_pin, gateway_slave_pin, failures, checks_done} = '0;
    s_axi_wstrb = 4'hF;
    wt(2);
    aresetn <= 1'b1;
    wt(4);
    foreach (rows[k])
    begin
      fire(14'h1 << rows[k][0]);
      axr(rows[k][1] ? GWC_IFL_ADDR : GWC_ERR_ADDR);
      chk("flag set", rdq[rows[k][2]], 1'b1);
      axw(GWC_CLR_ADDR, 32'h1 << rows[k][3]);
      axr(rows[k][1] ? GWC_IFL_ADDR : GWC_ERR_ADDR);
      chk("flag clear", rdq[rows[k][2]], 1'b0);
    end
    axr(GWC_CLR_ADDR);
    chk("clear reads zero", rdq, 32'h0);
    axw(32'h04001E10, 32'h7FF);
    chk("bad write", rsp, RESP_SLVERR);
    fire(14'h1);
    axw(GWC_CLR_ADDR, 32'h7FB);
    axw(GWC_CLR_ADDR, 32'h0);
    axr(GWC_ERR_ADDR);
    chk("parity kept", rdq[E_AP], 1'b1);
    fire(14'h1800);
    axr(GWC_IFL_ADDR);
    chk("ready with resume", rdq[F_RWAIT], 1'b0);
    // parcel count load beside a ready with no resume
    pc <= 3'h5;
    pcwe <= 1'b1;
    fire(14'h0800);
    pcwe <= 1'b0;
    axr(GWC_ERR_ADDR);
    chk("parcel count", rdq[E_PC_LO +: 3], 3'h5);
    axw(GWC_CLR_ADDR, 32'h1);
    axr(GWC_ERR_ADDR);
    chk("count cleared", rdq[E_PC_LO +: 3], 3'h0);
    axr(GWC_IFL_ADDR);
    chk("waiting kept", rdq[F_RWAIT], 1'b1);
    // software drops a stale ready after an aborted input
    axw(GWC_CLR_ADDR, 32'h20);
    axr(GWC_IFL_ADDR);
    chk("waiting clear", rdq[F_RWAIT], 1'b0);
    for (int o = 0; o < 2; o++)
      for (int s = 0; s < 2; s++)
      begin
        node_output_pin <= o[0];
        gateway_slave_pin <= s[0];
        wt(4);
        for (int b = 0; b < 7; b++)
        begin
          seen = '0;
          axw(GWC_CLR_ADDR, 32'h1 << b);
          wt(2);
          chk("pulses", seen, pexp(b, o[0], s[0]));
        end
      end
    node_output_pin <= 1'b0;
    want <= 4'h1;
    wt(6);
    want <= 4'h0;
    wt(6);
    @(negedge aclk);
    chk("unrecov held", hs_unrecov_drive, 1'b1);
    @(posedge aclk);
    axw(GWC_CFG_ADDR, 32'h0);
    axr(GWC_ERR_ADDR);
    chk("unrecov clear", rdq[E_UNR], 1'b0);
    gateway_slave_pin <= 1'b0;
    want <= 4'h2;
    wt(6);
    want <= 4'h0;
    wt(6);
    axr(GWC_IFL_ADDR);
    chk("held error", rdq[F_HAE], 1'b1);
    // software drops the held lines after an address error
    axw(GWC_CLR_ADDR, 32'h4);
    axr(GWC_IFL_ADDR);
    chk("held error clear", rdq[F_HAE], 1'b0);
    // reset in mid-run drops flags and reopens the bus ready slots
    fire(14'h0001);
    aresetn <= 1'b0;
    wt(2);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("reset status", {err_status, iflags}, 32'h0);
    @(negedge aclk);
    chk("ready after reset", {s_axi_awready, s_axi_wready, s_axi_arready}, 32'h7);
    complete_run();
  end
endmodule
bind gwc_ctrl gwc_ctrl_assertions chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ev_addr_parity,
  .ev_addr_ready_unexp, .hs_unrecov_drive, .hs_data_reset, .ls_in_sm_reset, .err_status);
